// [design/pvg_pkg.sv]
`default_nettype none
package pvg_pkg;
  // widths
  localparam int LVL_W  = 3;                    // priority level width
  localparam int NSRC   = 6;                    // implemented request sources
  localparam int DATA_W = 16;                   // processor data bus width
  localparam int ADDR_W = 23;                   // word address, bits 23..1

  // request source indices, also level minus one
  localparam int SRC_FIBER = 0;
  localparam int SRC_OWN_A = 1;
  localparam int SRC_OWN_B = 2;
  localparam int SRC_NET_A = 3;
  localparam int SRC_NET_B = 4;
  localparam int SRC_WDT   = 5;

  // priority levels on the priority_level_lines
  localparam logic [LVL_W-1:0] LVL_NONE  = 3'h0;
  localparam logic [LVL_W-1:0] LVL_FIBER = 3'h1;
  localparam logic [LVL_W-1:0] LVL_OWN_A = 3'h2;
  localparam logic [LVL_W-1:0] LVL_OWN_B = 3'h3;
  localparam logic [LVL_W-1:0] LVL_NET_A = 3'h4;
  localparam logic [LVL_W-1:0] LVL_NET_B = 3'h5;
  localparam logic [LVL_W-1:0] LVL_WDT   = 3'h6;
  localparam logic [LVL_W-1:0] LVL_NEVER = 3'h7;

  // vectors (41..46 decimal)
  localparam logic [7:0] VEC_FIBER = 8'h29;
  localparam logic [7:0] VEC_OWN_A = 8'h2a;
  localparam logic [7:0] VEC_OWN_B = 8'h2b;
  localparam logic [7:0] VEC_NET_A = 8'h2c;
  localparam logic [7:0] VEC_NET_B = 8'h2d;
  localparam logic [7:0] VEC_WDT   = 8'h2e;
  localparam logic [7:0] VEC_HI    = 8'h00;     // upper data byte during acknowledge

  // bus decode
  localparam logic [2:0]        FC_IACK         = 3'h7;        // acknowledge cycle code
  localparam logic [ADDR_W-1:0] TIMER_ACK_WADDR = 23'h002000;  // byte 04000
  localparam logic [DATA_W-1:0] DATA_IDLE       = 16'h0000;

  // processor bus pins as sampled
  typedef struct packed {
    logic              as_n;   // address strobe, low active
    logic              rw;     // high for read
    logic [2:0]        fc;     // function_code_lines
    logic [ADDR_W-1:0] addr;   // address bits 23..1
  } pvg_bus_s;

  localparam pvg_bus_s BUS_IDLE = '{as_n: 1'b1, rw: 1'b1, fc: 3'h0, addr: 23'h000000};

  // vector for an acknowledged level
  function automatic logic [7:0] pvg_vec_of(input logic [LVL_W-1:0] lvl);
    logic [7:0] v;
    v = 8'h00;
    case (lvl)
      LVL_FIBER: v = VEC_FIBER;
      LVL_OWN_A: v = VEC_OWN_A;
      LVL_OWN_B: v = VEC_OWN_B;
      LVL_NET_A: v = VEC_NET_A;
      LVL_NET_B: v = VEC_NET_B;
      LVL_WDT:   v = VEC_WDT;
      default:   v = 8'h00;
    endcase
    return v;
  endfunction : pvg_vec_of
endpackage : pvg_pkg
`default_nettype wire

// [design/pvg_prio_enc.sv]
`timescale 1ns/1ps
`default_nettype none
// highest pending request wins; none pending gives level zero
module pvg_prio_enc
  import pvg_pkg::*;
(
  input  wire logic [NSRC-1:0]  req,
  output logic      [LVL_W-1:0] level
);
  logic [LVL_W-1:0] hit [NSRC:0];   // running result up the chain

  assign hit[0] = LVL_NONE;

  // one stage per source, higher index overrides
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_stage
      assign hit[g+1] = req[g] ? LVL_W'(g + 1) : hit[g];
    end
  endgenerate

  assign level = hit[NSRC];
endmodule : pvg_prio_enc
`default_nettype wire

// [design/pvg_top.sv]
// Behaviour
// RULE1: present highest pending level on priority lines
// RULE2: processor services only levels above its mask
// RULE3: forward highest level, keep others pending
// RULE4: processor puts acknowledged level on A1-A3
// RULE5: drive vector only in acknowledge cycles
// RULE6: watchdog uses level 6, vector 46
// RULE7: second controller status at level 5
// RULE8: first controller status at level 4
// RULE9: second port ownership at level 3
// RULE10: first port ownership at level 2
// RULE11: fiber self-test level 1, gated
// RULE12: ownership update raises that port's request
// RULE13: read of 04000 clears timer request
// RULE14: requests hold; zero idle; seven never
// RULE15: release data bus when acknowledge ends
`timescale 1ns/1ps
`default_nettype none
module pvg_top
  import pvg_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              wdt_tick,          // watchdog expiry pulse
  input  wire logic [15:0]       net_a_status,      // controller_status_register_zero flags, A
  input  wire logic [15:0]       net_b_status,      // controller_status_register_zero flags, B
  input  wire logic              own_a_update,      // ownership bit written by port A
  input  wire logic              own_b_update,      // ownership bit written by port B
  input  wire logic              own_a_clr,         // processor cleared port A ownership
  input  wire logic              own_b_clr,         // processor cleared port B ownership
  input  wire logic              selftest_active,   // self-test running
  input  wire logic              fiber_present,     // fiber-optic module fitted
  input  wire logic              fiber_test_req,    // fiber circuitry test request
  input  wire pvg_bus_s          cpu_bus,           // processor bus pins, asynchronous
  output logic      [LVL_W-1:0]  priority_level_lines,
  output logic      [DATA_W-1:0] vec_data,
  output logic                   vec_data_oe
);
  // pin synchroniser stages
  pvg_bus_s bus_s1_q;                      // first stage, read only by second
  pvg_bus_s bus_q;                         // usable bus view
  logic     as_prev_q;                     // strobe one cycle back

  // sticky sources
  logic wdt_q;                             // watchdog pending
  logic own_a_q;                           // port A ownership pending
  logic own_b_q;                           // port B ownership pending

  // combinational views
  logic [NSRC-1:0]  pend;                  // all pending requests
  logic [LVL_W-1:0] enc_level;             // encoder result
  logic             ack_now;               // acknowledge cycle in progress
  logic             timer_read;            // start of a read at 04000
  logic [LVL_W-1:0] ack_level;             // level on A1-A3

  // two-flop synchroniser for processor pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_s1_q <= BUS_IDLE;
      bus_q    <= BUS_IDLE;
    end else begin
      bus_s1_q <= cpu_bus;
      bus_q    <= bus_s1_q;
    end
  end

  // strobe history for start-of-cycle detect
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      as_prev_q <= 1'b1;
    end else begin
      as_prev_q <= bus_q.as_n;
    end
  end

  // bus cycle decode
  assign ack_now    = !bus_q.as_n && (bus_q.fc == FC_IACK);             // RULE5
  assign ack_level  = bus_q.addr[LVL_W-1:0];                           // RULE4
  assign timer_read = !bus_q.as_n && as_prev_q && bus_q.rw &&
                      (bus_q.fc != FC_IACK) &&
                      (bus_q.addr == TIMER_ACK_WADDR);                 // RULE13

  // watchdog request, set wins over the clearing read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wdt_q <= 1'b0;
    end else if (wdt_tick) begin
      wdt_q <= 1'b1;                                                  // RULE6
    end else if (timer_read) begin
      wdt_q <= 1'b0;                                                  // RULE13
    end
  end

  // ownership requests, held until the processor clears them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      own_a_q <= 1'b0;
      own_b_q <= 1'b0;
    end else begin
      // port A
      if (own_a_update) begin
        own_a_q <= 1'b1;                                              // RULE10 RULE12
      end else if (own_a_clr) begin
        own_a_q <= 1'b0;                                              // RULE14
      end
      // port B
      if (own_b_update) begin
        own_b_q <= 1'b1;                                              // RULE9 RULE12
      end else if (own_b_clr) begin
        own_b_q <= 1'b0;                                              // RULE14
      end
    end
  end

  // gather the pending set; status sources are levels from the controllers
  always_comb begin
    pend            = '0;
    pend[SRC_WDT]   = wdt_q;                                          // RULE6
    pend[SRC_NET_B] = |net_b_status;                                  // RULE7
    pend[SRC_NET_A] = |net_a_status;                                  // RULE8
    pend[SRC_OWN_B] = own_b_q;                                        // RULE9
    pend[SRC_OWN_A] = own_a_q;                                        // RULE10
    pend[SRC_FIBER] = fiber_test_req && selftest_active && fiber_present; // RULE11
  end

  // highest pending level
  pvg_prio_enc pvg_prio_enc_i (
    .req   (pend),
    .level (enc_level)
  );

  // registered priority lines; the processor masks by its own level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      priority_level_lines <= LVL_NONE;
    end else begin
      priority_level_lines <= enc_level;                             // RULE1 RULE2 RULE3
    end
  end

  // vector driver: only levels 1..6, released when the strobe rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vec_data    <= DATA_IDLE;
      vec_data_oe <= 1'b0;
    end else if (ack_now && (ack_level != LVL_NONE) && (ack_level != LVL_NEVER)) begin
      vec_data    <= {VEC_HI, pvg_vec_of(ack_level)};               // RULE5
      vec_data_oe <= 1'b1;
    end else begin
      vec_data    <= DATA_IDLE;
      vec_data_oe <= 1'b0;                                           // RULE15
    end
  end

  // checks
  chk_level_never_seven: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    priority_level_lines != LVL_NEVER)
    else $error("priority level seven driven");

  chk_idle_level_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    (pend == '0) |=> (priority_level_lines == LVL_NONE))
    else $error("level not zero with nothing pending");

  chk_wdt_top_level: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    wdt_tick ##1 1'b1 |=> (priority_level_lines == LVL_WDT))
    else $error("watchdog not presented at level six");

  chk_net_b_level: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    (|net_b_status && !wdt_q) |=> (priority_level_lines == LVL_NET_B))
    else $error("second controller not at level five");

  chk_net_a_level: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
    (|net_a_status && pend[NSRC-1:SRC_NET_A+1] == '0) |=>
      (priority_level_lines == LVL_NET_A))
    else $error("first controller not at level four");

  chk_own_b_raise: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
    own_b_update ##1 (pend[NSRC-1:SRC_OWN_B+1] == '0) |=>
      (priority_level_lines == LVL_OWN_B))
    else $error("port B ownership not at level three");

  chk_own_a_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    own_a_update ##1 !own_a_clr[*3] |-> own_a_q)
    else $error("port A ownership request dropped");

  chk_fiber_gate: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
    (!selftest_active || !fiber_present) && (pend[NSRC-1:SRC_FIBER+1] == '0) |=>
      (priority_level_lines == LVL_NONE))
    else $error("fiber request outside self-test");

  chk_lower_stays: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    (own_a_q && wdt_q && !own_a_clr) |=> own_a_q)
    else $error("lower request lost behind higher one");

  chk_timer_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
    (timer_read && !wdt_tick) |=> !wdt_q)
    else $error("timer read did not clear request");

  chk_vector_value: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    vec_data_oe |-> (vec_data[7:0] == 8'h28 + {5'h00, $past(ack_level)}) &&
                    $past(ack_now))
    else $error("wrong vector or driven outside acknowledge");

  chk_bus_release: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    $rose(bus_q.as_n) |=> !vec_data_oe)
    else $error("data bus held after acknowledge");

  // set beats a clearing read in the same cycle
  chk_wdt_set_wins: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    wdt_tick |=> wdt_q)
    else $error("watchdog pulse lost against clearing read");

  // level six acknowledge returns vector 46
  chk_wdt_vector: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    (ack_now && (ack_level == LVL_WDT)) |=>
      (vec_data_oe && (vec_data == {VEC_HI, VEC_WDT})))
    else $error("watchdog acknowledge without its vector");

  // ownership updates always latch, even against a clear
  chk_own_a_wins: assert property (@(posedge sys_clk) disable iff (rst) // RULE10 RULE12
    own_a_update |=> own_a_q)
    else $error("port A ownership update not latched");

  chk_own_b_wins: assert property (@(posedge sys_clk) disable iff (rst) // RULE9 RULE12
    own_b_update |=> own_b_q)
    else $error("port B ownership update not latched");

  // a clear alone drops the held request
  chk_own_a_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    (own_a_clr && !own_a_update) |=> !own_a_q)
    else $error("port A ownership request not cleared");

  // anything pending shows a nonzero level next cycle
  chk_pending_shown: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    (pend != '0) |=> (priority_level_lines != LVL_NONE))
    else $error("pending request not presented");

  // released bus carries the idle word
  chk_vec_idle_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    !vec_data_oe |-> (vec_data == DATA_IDLE))
    else $error("data bus value while released");
endmodule : pvg_top
`default_nettype wire

// [tb/pvg_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// processor side: bus cycles and the priority mask
module pvg_cpu_model
  import pvg_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic [DATA_W-1:0] vec_data,
  input  wire logic              vec_data_oe,
  output var  pvg_bus_s          cpu_bus
);
  logic [LVL_W-1:0] mask_q = 3'h0; // current processor priority mask
  initial cpu_bus = BUS_IDLE;
  // taken only when strictly above the mask
  function automatic logic wants(input logic [LVL_W-1:0] lvl);
    return lvl > mask_q;
  endfunction : wants
  // one strobed cycle, held until the answer is sampled
  task automatic cycle(input logic [2:0] fc, input logic [ADDR_W-1:0] a,
                       output logic [DATA_W-1:0] d, output logic oe);
    @(posedge sys_clk);
    cpu_bus <= '{as_n: 1'b0, rw: 1'b1, fc: fc, addr: a};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    d = vec_data;
    oe = vec_data_oe;
    @(posedge sys_clk);
    // released lines no longer show the last value
    cpu_bus <= '{as_n: 1'b1, rw: 1'b1, fc: ~fc, addr: ~a};
  endtask : cycle
  // acknowledge with the level on address bits one to three
  task automatic iack(input logic [2:0] lvl, output logic [DATA_W-1:0] d, output logic oe);
    cycle(FC_IACK, {20'h00000, lvl}, d, oe);
  endtask : iack
endmodule : pvg_cpu_model
`default_nettype wire

// [tb/prioritized_interrupt_vectoring_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_vectoring_bench;
  import pvg_pkg::*;
  logic              sys_clk, rst, wdt_tick, own_a_update, own_b_update;
  logic              own_a_clr, own_b_clr, selftest_active, fiber_present, fiber_test_req;
  logic [15:0]       net_a_status, net_b_status;
  pvg_bus_s          cpu_bus;
  logic [LVL_W-1:0]  priority_level_lines;
  logic [DATA_W-1:0] vec_data, d;
  logic              vec_data_oe, oe;
  int                n_fail = 0;
  int                check_count = 0;

  pvg_top pvg_top_i (.sys_clk(sys_clk), .rst(rst), .wdt_tick(wdt_tick),
    .net_a_status(net_a_status), .net_b_status(net_b_status), .own_a_update(own_a_update),
    .own_b_update(own_b_update), .own_a_clr(own_a_clr), .own_b_clr(own_b_clr),
    .selftest_active(selftest_active), .fiber_present(fiber_present),
    .fiber_test_req(fiber_test_req), .cpu_bus(cpu_bus),
    .priority_level_lines(priority_level_lines), .vec_data(vec_data),
    .vec_data_oe(vec_data_oe));
  pvg_cpu_model pvg_cpu_model_i (.sys_clk(sys_clk), .vec_data(vec_data),
    .vec_data_oe(vec_data_oe), .cpu_bus(cpu_bus));

  // 25 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // let n edges pass, sample at the falling edge
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic set_src(input int s);
    @(posedge sys_clk);
    case (s)
      SRC_FIBER: fiber_test_req <= 1'b1;
      SRC_OWN_A: own_a_update <= 1'b1;
      SRC_OWN_B: own_b_update <= 1'b1;
      SRC_NET_A: net_a_status <= 16'h0200;
      SRC_NET_B: net_b_status <= 16'h8000;
      default:   wdt_tick <= 1'b1;
    endcase
    @(posedge sys_clk);
    own_a_update <= 1'b0;
    own_b_update <= 1'b0;
    wdt_tick <= 1'b0;
  endtask : set_src
  task automatic clr_src(input int s);
    if (s == SRC_WDT) pvg_cpu_model_i.cycle(3'h5, TIMER_ACK_WADDR, d, oe);
    else begin
      @(posedge sys_clk);
      fiber_test_req <= (s == SRC_FIBER) ? 1'b0 : fiber_test_req;
      own_a_clr <= (s == SRC_OWN_A);
      own_b_clr <= (s == SRC_OWN_B);
      net_a_status <= (s == SRC_NET_A) ? 16'h0000 : net_a_status;
      net_b_status <= (s == SRC_NET_B) ? 16'h0000 : net_b_status;
      @(posedge sys_clk);
      own_a_clr <= 1'b0;
      own_b_clr <= 1'b0;
    end
  endtask : clr_src
  // idle after reset
  task automatic t_reset;
    chk("idle level", 16'(priority_level_lines), 16'h0000);
    chk("idle oe", 16'(vec_data_oe), 16'h0000);
    $display("test reset done");
  endtask : t_reset
  // each source alone: level, vector, release, clear
  task automatic t_each;
    for (int s = 0; s < NSRC; s++) begin
      set_src(s);
      settle(3);
      chk("level", 16'(priority_level_lines), 16'(s + 1));
      pvg_cpu_model_i.iack(3'(s + 1), d, oe);
      chk("vector", d, {VEC_HI, VEC_FIBER + 8'(s)});
      chk("ack oe", 16'(oe), 16'h0001);
      settle(4);
      chk("oe after", 16'(vec_data_oe), 16'h0000);
      chk("data after", vec_data, DATA_IDLE);
      chk("held", 16'(priority_level_lines), 16'(s + 1));
      clr_src(s);
      settle(4);
      chk("cleared", 16'(priority_level_lines), 16'h0000);
    end
    $display("test each source done");
  endtask : t_each
  // simultaneous requests, highest first, rest wait
  task automatic t_prio;
    set_src(SRC_FIBER);
    set_src(SRC_NET_B);
    set_src(SRC_OWN_A);
    settle(3);
    chk("top", 16'(priority_level_lines), 16'(LVL_NET_B));
    pvg_cpu_model_i.mask_q = LVL_NET_B;
    chk("masked", 16'(pvg_cpu_model_i.wants(priority_level_lines)), 16'h0000);
    pvg_cpu_model_i.mask_q = LVL_NET_A;
    chk("unmasked", 16'(pvg_cpu_model_i.wants(priority_level_lines)), 16'h0001);
    pvg_cpu_model_i.mask_q = 3'h0;
    clr_src(SRC_NET_B);
    settle(3);
    chk("next", 16'(priority_level_lines), 16'(LVL_OWN_A));
    clr_src(SRC_OWN_A);
    settle(3);
    chk("last", 16'(priority_level_lines), 16'(LVL_FIBER));
    clr_src(SRC_FIBER);
    $display("test priority done");
  endtask : t_prio
  // no drive outside acknowledge; fiber gating
  task automatic t_gate;
    set_src(SRC_WDT);
    pvg_cpu_model_i.cycle(3'h5, 23'h000006, d, oe);
    chk("no ack oe", 16'(oe), 16'h0000);
    chk("no ack data", d, DATA_IDLE);
    settle(0);
    chk("wdt kept", 16'(priority_level_lines), 16'(LVL_WDT));
    clr_src(SRC_WDT);
    pvg_cpu_model_i.iack(LVL_NONE, d, oe);
    chk("level0 oe", 16'(oe), 16'h0000);
    chk("level0 data", d, DATA_IDLE);
    fiber_present <= 1'b0;
    set_src(SRC_FIBER);
    settle(3);
    chk("no module", 16'(priority_level_lines), 16'h0000);
    @(posedge sys_clk);
    selftest_active <= 1'b0;
    fiber_present <= 1'b1;
    settle(3);
    chk("no selftest", 16'(priority_level_lines), 16'h0000);
    $display("test gating done");
  endtask : t_gate
  // update and clear in one cycle: the update wins
  task automatic t_race;
    @(posedge sys_clk);
    own_b_update <= 1'b1;
    own_b_clr    <= 1'b1;
    @(posedge sys_clk);
    own_b_update <= 1'b0;
    own_b_clr    <= 1'b0;
    settle(3);
    chk("set wins", 16'(priority_level_lines), 16'(LVL_OWN_B));
    clr_src(SRC_OWN_B);
    settle(3);
    chk("race cleared", 16'(priority_level_lines), 16'h0000);
    $display("test set wins done");
  endtask : t_race
  // reset in mid-run drops sticky requests
  task automatic t_midreset;
    set_src(SRC_WDT);
    set_src(SRC_OWN_A);
    settle(3);
    chk("before reset", 16'(priority_level_lines), 16'(LVL_WDT));
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    settle(1);
    chk("reset edge1", 16'(priority_level_lines), 16'h0000);
    chk("reset oe", 16'(vec_data_oe), 16'h0000);
    settle(0);
    chk("reset edge2", 16'(priority_level_lines), 16'h0000);
    settle(3);
    chk("sticky gone", 16'(priority_level_lines), 16'h0000);
    $display("test mid reset done");
  endtask : t_midreset
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    {wdt_tick, own_a_update, own_b_update, own_a_clr, own_b_clr, fiber_test_req} = 6'h00;
    {selftest_active, fiber_present} = 2'h3;
    net_a_status = 16'h0000;
    net_b_status = 16'h0000;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    settle(3);
    t_reset();
    t_each();
    t_prio();
    t_race();
    t_midreset();
    t_gate();
    report_and_stop();
  end
endmodule : prioritized_interrupt_vectoring_bench
`default_nettype wire
